// file: lcs_pkg.sv
package lcs_pkg;
  // ----------------------------------------------------------------
  // command codes and paging
  // ----------------------------------------------------------------
  localparam logic [7:0] LCS_CMD_LOOP_COMP = 8'hD7;
  localparam logic [7:0] LCS_CMD_MARGIN_HIGH = 8'h25;
  localparam logic [7:0] LCS_CMD_OPERATION = 8'h01;
  localparam logic [7:0] LCS_PAGE_A = 8'h00;
  localparam logic [7:0] LCS_PAGE_B = 8'h01;
  localparam logic [7:0] LCS_PAGE_BOTH = 8'hFF;
  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int LCS_INT_GAIN_LSB = 12;
  localparam int LCS_INTEGRATION_TIME_CONSTANT_LSB = 8;
  localparam int LCS_AC_PATH_GAIN_SELECT_LSB = 6;
  localparam int LCS_AC_LOAD_LINE_SELECT_LSB = 0;
  localparam logic [15:0] LCS_LOOP_WMASK = 16'h3FFF;
  localparam logic [15:0] LCS_MARGIN_WMASK = 16'h00FF;
  localparam int LCS_MARGIN_LSB = 2;
  localparam logic [3:0] LCS_MARGIN_HIGH_IGN = 4'h9;
  localparam logic [3:0] LCS_MARGIN_HIGH_ACT = 4'hA;
  // ----------------------------------------------------------------
  // decoded settings
  // ----------------------------------------------------------------
  // gains in quarter units: x0.66 rounds to 3 sixteenths-of-four steps is too coarse,
  // so integration gain is given in hundredths of the ac_path_gain_select
  localparam logic [7:0] LCS_IGAIN_X2 = 8'hC8;
  localparam logic [7:0] LCS_IGAIN_X1 = 8'h64;
  localparam logic [7:0] LCS_IGAIN_X066 = 8'h42;
  localparam logic [7:0] LCS_IGAIN_X05 = 8'h32;
  // ac_path_gain_select in tenths
  localparam logic [4:0] LCS_AGAIN_1 = 5'h0A;
  localparam logic [4:0] LCS_AGAIN_15 = 5'h0F;
  localparam logic [4:0] LCS_AGAIN_2 = 5'h14;
  localparam logic [4:0] LCS_AGAIN_05 = 5'h05;
  localparam logic [5:0] LCS_TC_COARSE_STEP_US = 6'h05;

  typedef struct packed {
    logic [7:0] int_gain_pct;   // percent of ac_path_gain_select
    logic [5:0] integration_time_constant_us;      // microseconds
    logic [4:0] ac_path_gain_select_tenths;
    logic [11:0] ac_load_line_uohm; // micro-ohms
  } lcs_loop_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] command;
    logic [15:0] data;
  } lcs_req_type;

  // decode of an all-zero word, shown on the loop outputs while reset is held
  localparam lcs_loop_type LCS_LOOP_RESET = '{LCS_IGAIN_X2, LCS_TC_COARSE_STEP_US, LCS_AGAIN_1,
    12'h000};
endpackage

// file: lcs_loop_compensation_config_regs.sv
// Operation
// - each channel holds an 8-bit vid margin-high target applied as setpoint while in margin high.
// - the loop compensation register is served as a 16-bit word by word reads and writes.
// - page 00h selects channel a, page 01h channel b, each with its own copy.
// - bits 15:14 of the loop compensation register read as zero.
// - bits 13:12 set integration gain as 2x, 1x, 0.66x or 0.5x of the ac_path_gain_select.
// - bits 11:8 decode to 5..40 us in 5 us steps, then 1..8 us in 1 us steps.
// - bits 7:6 set ac_path_gain_select to 1, 1.5, 2 or 0.5.
// - bits 5:0 map through a fixed table to ac load lines from 0 to 3.125 milliohm.
// - all loop settings are kept independently for the two channels.
// - integration gain and ac_path_gain_select come from separate fields and never disturb each other.
// - ramp amplitude and dc load line are not taken from this register.
// - margin field 1001b or 1010b selects margin high operation.
`timescale 1ns/1ns
`default_nettype none
module lcs_loop_compensation_config_regs
  import lcs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [7:0] i_page,
  input wire lcs_req_type i_req,
  input wire logic [15:0] i_nvm_loop_a,
  input wire logic [15:0] i_nvm_loop_b,
  input wire logic [7:0] i_nvm_margin_a,
  input wire logic [7:0] i_nvm_margin_b,
  input wire logic [7:0] i_vout_command_a,
  input wire logic [7:0] i_vout_command_b,
  input wire logic [7:0] i_ramp_amplitude_setup_a,
  input wire logic [7:0] i_ramp_amplitude_setup_b,
  input wire logic [15:0] i_dc_load_line_setting_a,
  input wire logic [15:0] i_dc_load_line_setting_b,
  output logic [15:0] o_rdata,
  output logic o_rvalid,
  output lcs_loop_type o_loop_a,
  output lcs_loop_type o_loop_b,
  output logic [7:0] o_setpoint_vid_a,
  output logic [7:0] o_setpoint_vid_b,
  output logic [7:0] o_ramp_a,
  output logic [7:0] o_ramp_b,
  output logic [15:0] o_dc_load_line_a,
  output logic [15:0] o_dc_load_line_b
);
  // ----------------------------------------------------------------
  // decode functions
  // ----------------------------------------------------------------
  function automatic logic [11:0] ac_load_line_select_uohm(input logic [5:0] code);
    logic [11:0] t [0:63];
    t = '{12'd0, 12'd125, 12'd250, 12'd313, 12'd375, 12'd438, 12'd500, 12'd563,
      12'd625, 12'd750, 12'd797, 12'd813, 12'd828, 12'd844, 12'd859, 12'd875,
      12'd891, 12'd906, 12'd922, 12'd938, 12'd953, 12'd969, 12'd984, 12'd1000,
      12'd1016, 12'd1031, 12'd1047, 12'd1063, 12'd1125, 12'd1250, 12'd1375, 12'd1500,
      12'd1625, 12'd1750, 12'd1875, 12'd1938, 12'd2000, 12'd2063, 12'd2125, 12'd2188,
      12'd2250, 12'd2375, 12'd2422, 12'd2438, 12'd2453, 12'd2469, 12'd2484, 12'd2500,
      12'd2516, 12'd2531, 12'd2547, 12'd2563, 12'd2578, 12'd2594, 12'd2609, 12'd2625,
      12'd2641, 12'd2656, 12'd2672, 12'd2688, 12'd2750, 12'd2875, 12'd3000, 12'd3125};
    return t[code];
  endfunction

  function automatic lcs_loop_type decode(input logic [15:0] w);
    lcs_loop_type d;
    logic [3:0] tc;
    d = '0;
    tc = w[LCS_INTEGRATION_TIME_CONSTANT_LSB +: 4];
    unique case (w[LCS_INT_GAIN_LSB +: 2])
      2'h0: d.int_gain_pct = LCS_IGAIN_X2;
      2'h1: d.int_gain_pct = LCS_IGAIN_X1;
      2'h2: d.int_gain_pct = LCS_IGAIN_X066;
      2'h3: d.int_gain_pct = LCS_IGAIN_X05;
    endcase
    if (tc[3])
      d.integration_time_constant_us = {3'h0, tc[2:0]} + 6'h01;
    else
      d.integration_time_constant_us = 6'(({3'h0, tc[2:0]} + 6'h01) * LCS_TC_COARSE_STEP_US);
    unique case (w[LCS_AC_PATH_GAIN_SELECT_LSB +: 2])
      2'h0: d.ac_path_gain_select_tenths = LCS_AGAIN_1;
      2'h1: d.ac_path_gain_select_tenths = LCS_AGAIN_15;
      2'h2: d.ac_path_gain_select_tenths = LCS_AGAIN_2;
      2'h3: d.ac_path_gain_select_tenths = LCS_AGAIN_05;
    endcase
    d.ac_load_line_uohm = ac_load_line_select_uohm(w[LCS_AC_LOAD_LINE_SELECT_LSB +: 6]);
    return d;
  endfunction

  // ----------------------------------------------------------------
  // paged register state
  // ----------------------------------------------------------------
  logic [15:0] loop_comp [0:1];
  logic [15:0] margin_high [0:1];
  logic [3:0] margin_mode [0:1];
  logic [15:0] next_loop_comp [0:1];
  logic [15:0] next_margin_high [0:1];
  logic [3:0] next_margin_mode [0:1];
  logic [15:0] rdata;
  logic [15:0] next_rdata;
  logic rvalid;
  logic next_rvalid;
  logic nvm_loaded;
  logic sel_a;
  logic sel_b;

  // ff reset is a constant, so nvm defaults are captured on the first clock after release
  always_comb
  begin
    sel_a = (i_page == LCS_PAGE_A) || (i_page == LCS_PAGE_BOTH);
    sel_b = (i_page == LCS_PAGE_B) || (i_page == LCS_PAGE_BOTH);
    next_loop_comp = loop_comp;
    next_margin_high = margin_high;
    next_margin_mode = margin_mode;
    next_rdata = rdata;
    next_rvalid = 1'b0;
    if (!nvm_loaded)
    begin
      next_loop_comp[0] = i_nvm_loop_a & LCS_LOOP_WMASK;
      next_loop_comp[1] = i_nvm_loop_b & LCS_LOOP_WMASK;
      next_margin_high[0] = {8'h00, i_nvm_margin_a};
      next_margin_high[1] = {8'h00, i_nvm_margin_b};
    end
    else if (i_req.valid && i_req.write)
    begin
      for (int c = 0; c < 2; c++)
      begin
        if ((c == 0) ? sel_a : sel_b)
        begin
          unique case (i_req.command)
            LCS_CMD_LOOP_COMP: next_loop_comp[c] = i_req.data & LCS_LOOP_WMASK;
            LCS_CMD_MARGIN_HIGH: next_margin_high[c] = i_req.data & LCS_MARGIN_WMASK;
            LCS_CMD_OPERATION: next_margin_mode[c] = i_req.data[LCS_MARGIN_LSB +: 4];
            default: ;
          endcase
        end
      end
    end
    else if (i_req.valid)
    begin
      // a read on the broadcast page answers from channel a
      next_rvalid = 1'b1;
      unique case (i_req.command)
        LCS_CMD_LOOP_COMP: next_rdata = loop_comp[sel_a ? 0 : 1] & LCS_LOOP_WMASK;
        LCS_CMD_MARGIN_HIGH: next_rdata = margin_high[sel_a ? 0 : 1];
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      loop_comp <= '{16'h0000, 16'h0000};
      margin_high <= '{16'h0000, 16'h0000};
      margin_mode <= '{4'h0, 4'h0};
      rdata <= 16'h0000;
      rvalid <= 1'b0;
      nvm_loaded <= 1'b0;
    end
    else
    begin
      loop_comp <= next_loop_comp;
      margin_high <= next_margin_high;
      margin_mode <= next_margin_mode;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      nvm_loaded <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // outputs to the analog loop
  // ----------------------------------------------------------------
  function automatic logic is_margin_high(input logic [3:0] m);
    return (m == LCS_MARGIN_HIGH_IGN) || (m == LCS_MARGIN_HIGH_ACT);
  endfunction

  // settings are decoded from the next register values, so the registered
  // outputs change on the same edge as the word itself and add no latency
  lcs_loop_type loop_out [0:1];
  lcs_loop_type next_loop_out [0:1];
  logic [7:0] setpoint [0:1];
  logic [7:0] next_setpoint [0:1];
  logic [7:0] ramp [0:1];
  logic [7:0] next_ramp [0:1];
  logic [15:0] dc_load_line [0:1];
  logic [15:0] next_dc_load_line [0:1];

  always_comb
  begin
    next_loop_out[0] = decode(next_loop_comp[0]);
    next_loop_out[1] = decode(next_loop_comp[1]);
    next_setpoint[0] = is_margin_high(next_margin_mode[0]) ?
      next_margin_high[0][7:0] : i_vout_command_a;
    next_setpoint[1] = is_margin_high(next_margin_mode[1]) ?
      next_margin_high[1][7:0] : i_vout_command_b;
    // ramp and dc load line are owned by their own registers; only retimed here
    next_ramp[0] = i_ramp_amplitude_setup_a;
    next_ramp[1] = i_ramp_amplitude_setup_b;
    next_dc_load_line[0] = i_dc_load_line_setting_a;
    next_dc_load_line[1] = i_dc_load_line_setting_b;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      loop_out <= '{LCS_LOOP_RESET, LCS_LOOP_RESET};
      setpoint <= '{8'h00, 8'h00};
      ramp <= '{8'h00, 8'h00};
      dc_load_line <= '{16'h0000, 16'h0000};
    end
    else
    begin
      loop_out <= next_loop_out;
      setpoint <= next_setpoint;
      ramp <= next_ramp;
      dc_load_line <= next_dc_load_line;
    end
  end

  // read handshake stays as registered by the bus logic above
  always_comb
  begin
    o_rdata = rdata;
    o_rvalid = rvalid;
    o_loop_a = loop_out[0];
    o_loop_b = loop_out[1];
    o_setpoint_vid_a = setpoint[0];
    o_setpoint_vid_b = setpoint[1];
    o_ramp_a = ramp[0];
    o_ramp_b = ramp[1];
    o_dc_load_line_a = dc_load_line[0];
    o_dc_load_line_b = dc_load_line[1];
  end
endmodule // lcs_loop_compensation_config_regs
`default_nettype wire

// file: lcs_host.sv
`timescale 1ns/1ns
`default_nettype none
module lcs_host
  import lcs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rvalid,
  input wire logic [15:0] i_rdata,
  output logic [7:0] o_page,
  output lcs_req_type o_req
);
  int unsigned tmo = 0;
  initial
  begin
    o_page = 8'h00;
    o_req = '0;
  end
  // writes leave valid up so the next call runs back to back
  task automatic xfer(input logic [7:0] pg, input logic wr, input logic [7:0] cmd,
    input logic [15:0] d, output logic [15:0] q);
    int n;
    @(posedge i_clk);
    o_page <= pg;
    o_req <= '{1'b1, wr, cmd, d};
    q = 16'h0000;
    if (!wr)
    begin
      @(posedge i_clk);
      o_req <= '{1'b0, 1'b1, ~cmd, ~d};
      n = 0;
      do
      begin
        @(posedge i_clk);
        n++;
      end while (i_rvalid !== 1'b1 && n < 4);
      tmo += 32'(i_rvalid !== 1'b1);
      q = i_rdata;
      repeat ($urandom % 3) @(posedge i_clk);
    end
  endtask
endmodule // lcs_host
`default_nettype wire

// file: lcs_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module lcs_checker
  import lcs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [7:0] i_page,
  input wire lcs_req_type i_req,
  input wire logic [15:0] o_rdata,
  input wire logic o_rvalid,
  input wire lcs_loop_type o_loop_a,
  input wire lcs_loop_type o_loop_b
);
  logic [15:0] d;
  logic [7:0] ig [4] = '{8'hC8, 8'h64, 8'h42, 8'h32};
  logic [4:0] ag [4] = '{5'h0A, 5'h0F, 5'h14, 5'h05};
  always_ff @(posedge i_clk)
  begin
    d <= i_req.data;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  sequence wr_a;
    i_req.valid && i_req.write && i_req.command == 8'hD7 && i_page == 8'h00;
  endsequence
  sequence rd;
    i_req.valid && !i_req.write;
  endsequence
  read_answer_a: assert property (rd |=> o_rvalid) else $error("no answer");
  quiet_valid_a: assert property (!i_req.valid |=> !o_rvalid) else $error("stray valid");
  top_zero_a: assert property (o_rvalid |-> o_rdata[15:14] == 2'b00) else $error("top bits");
  int_gain_a: assert property (wr_a |=> o_loop_a.int_gain_pct == ig[d[13:12]])
    else $error("int gain");
  integration_time_constant_a: assert property (wr_a |=> o_loop_a.integration_time_constant_us ==
    (d[11] ? 6'(d[10:8]) + 6'h01 : 6'(d[10:8]) * 6'h05 + 6'h05)) else $error("integration_time_constant");
  ac_path_gain_select_a: assert property (wr_a |=> o_loop_a.ac_path_gain_select_tenths == ag[d[7:6]])
    else $error("ac_path_gain_select");
  chan_indep_a: assert property (wr_a |=> $stable(o_loop_b)) else $error("chan b moved");
  ac_load_line_select_max_a: assert property (wr_a ##0 i_req.data[5:0] == 6'h3F |=>
    o_loop_a.ac_load_line_uohm == 12'hC35) else $error("ac_load_line_select top");
endmodule // lcs_checker
bind lcs_loop_compensation_config_regs lcs_checker i_chk (.i_clk(i_clk), .i_arst_n(i_arst_n),
  .i_page(i_page), .i_req(i_req), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
  .o_loop_a(o_loop_a), .o_loop_b(o_loop_b));
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import lcs_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] page, nm [2], vc [2], rp [2], rpo [2], sp [2];
  logic [15:0] nl [2], dc [2], dco [2], q, w, mh, rdata;
  logic [3:0] ops [4] = '{4'h0, 4'h9, 4'hA, 4'h5};
  logic [5:0] ll_code [9] = '{6'h00, 6'h01, 6'h09, 6'h17, 6'h1F, 6'h24, 6'h29, 6'h2F, 6'h3F};
  logic [11:0] ll_uohm [9] = '{12'h000, 12'h07D, 12'h2EE, 12'h3E8, 12'h5DC, 12'h7D0, 12'h947,
    12'h9C4, 12'hC35};
  logic [13:0] mdl [2];
  logic rvalid;
  lcs_req_type req;
  lcs_loop_type lp [2];
  int err_count = 0, compares = 0, c;
  always #50 clk = ~clk;
  lcs_host i_host (.i_clk(clk), .i_rvalid(rvalid), .i_rdata(rdata), .o_page(page), .o_req(req));
  lcs_loop_compensation_config_regs i_dut (.i_clk(clk), .i_arst_n(arst_n), .i_page(page),
    .i_req(req), .i_nvm_loop_a(nl[0]), .i_nvm_loop_b(nl[1]), .i_nvm_margin_a(nm[0]),
    .i_nvm_margin_b(nm[1]), .i_vout_command_a(vc[0]), .i_vout_command_b(vc[1]),
    .i_ramp_amplitude_setup_a(rp[0]), .i_ramp_amplitude_setup_b(rp[1]),
    .i_dc_load_line_setting_a(dc[0]), .i_dc_load_line_setting_b(dc[1]), .o_rdata(rdata),
    .o_rvalid(rvalid), .o_loop_a(lp[0]), .o_loop_b(lp[1]), .o_setpoint_vid_a(sp[0]),
    .o_setpoint_vid_b(sp[1]), .o_ramp_a(rpo[0]), .o_ramp_b(rpo[1]),
    .o_dc_load_line_a(dco[0]), .o_dc_load_line_b(dco[1]));
  // expected gains and time constant, packed as {int gain, tc, ac_path_gain_select}
  function automatic logic [47:0] dec(input logic [13:0] v);
    logic [7:0] g;
    g = v[13] ? (v[12] ? 8'h32 : 8'h42) : (v[12] ? 8'h64 : 8'hC8);
    return {29'h0, g, v[11] ? 6'(v[10:8]) + 6'h01 : 6'(v[10:8]) * 6'h05 + 6'h05,
      v[7] ? (v[6] ? 5'h05 : 5'h14) : (v[6] ? 5'h0F : 5'h0A)};
  endfunction
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    err_count += int'(i_host.tmo);
    if (err_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // every access goes through here, so a lost answer ends the run at once
  task automatic bus(input logic [7:0] pg, input logic wr, input logic [7:0] cmd,
    input logic [15:0] d);
    i_host.xfer(pg, wr, cmd, d, q);
    if (i_host.tmo != 0)
      finish_test();
  endtask
  initial
  begin
    void'($urandom(32'h3600CD22));
    {nl[0], nl[1], nm[0], nm[1]} = 48'({$urandom, $urandom});
    {vc[0], vc[1], rp[0], rp[1], dc[0], dc[1]} = 64'({$urandom, $urandom});
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    for (c = 0; c < 2; c++)
    begin
      bus(8'(c), 1'b0, 8'hD7, 16'h0000);
      chk(q, nl[c] & 16'h3FFF);
      mdl[c] = nl[c][13:0];
    end
    for (int n = 0; n < 40; n++)
    begin
      c = n < 2 ? n : int'($urandom % 2);
      w = n == 0 ? 16'hFFFF : (n == 1 ? 16'hC000 : 16'($urandom));
      bus(8'(c), 1'b1, 8'hD7, w);
      mdl[c] = w[13:0];
      bus(8'(c), 1'b0, 8'hD7, 16'h0000);
      chk(q, {2'b00, mdl[c]});
      for (int k = 0; k < 2; k++)
        chk({lp[k].int_gain_pct, lp[k].integration_time_constant_us, lp[k].ac_path_gain_select_tenths}, dec(mdl[k]));
      if (w[5:0] == 6'h00)
        chk(lp[c].ac_load_line_uohm, 12'h000);
    end
    foreach (ll_code[k])
    begin
      c = int'($urandom % 2);
      bus(8'(c), 1'b1, 8'hD7, {10'h000, ll_code[k]});
      bus(8'(c), 1'b0, 8'hD7, 16'h0000);
      chk(lp[c].ac_load_line_uohm, ll_uohm[k]);
    end
    w = 16'($urandom);
    bus(8'hFF, 1'b1, 8'hD7, w);
    bus(8'h02, 1'b1, 8'hD7, ~w);
    for (c = 0; c < 2; c++)
    begin
      bus(8'(c), 1'b0, 8'hD7, 16'h0000);
      chk(q, w & 16'h3FFF);
      mh = 16'($urandom);
      bus(8'(c), 1'b1, 8'h25, mh);
      foreach (ops[k])
      begin
        bus(8'(c), 1'b1, 8'h01, {10'h002, ops[k], 2'b00});
        bus(8'(c), 1'b0, 8'h25, 16'h0000);
        chk(q, {8'h00, mh[7:0]});
        chk(sp[c], ops[k][3] ? mh[7:0] : vc[c]);
        chk(sp[1 - c], vc[1 - c]);
      end
    end
    {rp[0], rp[1], dc[0], dc[1]} <= 48'({$urandom, $urandom});
    repeat (2) @(posedge clk);
    chk({rpo[0], rpo[1], dco[0], dco[1]}, {rp[0], rp[1], dc[0], dc[1]});
    finish_test();
  end
endmodule // testbench
`default_nettype wire
